// ### pfs_sequencer.sv
// Program flash self-programming sequencer with Wishbone register slave
`timescale 1ns/100ps
`default_nettype none
module pfs_sequencer
  import pfs_pkg::*;
#(
  parameter int LONG_CNT = pfs_pkg::LONG_CYCLES
) (
  // Clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   reset_in,
  // Wishbone slave
  input  wire logic                   wb_cyc_in,
  input  wire logic                   wb_stb_in,
  input  wire logic                   wb_we_in,
  input  wire logic [7:0]             wb_adr_in,
  input  wire logic [3:0]             wb_sel_in,
  input  wire logic [31:0]            wb_dat_in,
  output logic      [31:0]            wb_dat_out,
  output logic                        wb_ack_out,
  // Flash array read port, data in the same cycle as address
  output logic      [20:0]            flash_raddr_out,
  input  wire logic [15:0]            flash_rdata_in,
  // Flash array erase and program requests
  output pfs_pkg::pfs_erase_t         flash_erase_out,
  output pfs_pkg::pfs_pgm_t           flash_pgm_out,
  // Core halt during long cycles
  output logic                        core_stall_out
);
  localparam int CW = $clog2(LONG_CNT + 1);

  pfs_state_t     state, next_state;
  pfs_unlock_t    unlock, next_unlock;
  logic [PTR_W-1:0] table_pointer, next_pointer;
  logic [7:0]     table_latch, next_latch;
  logic           pgm_sel, next_pgm_sel, cfg_sel, next_cfg_sel;
  logic           erase_sel, next_erase_sel, wr_en, next_wr_en;
  logic           start, next_start, wr_err, next_wr_err;
  logic           done_flag, next_done_flag;
  logic           rd_hi, next_rd_hi;
  logic [IDX_W-1:0] idx, next_idx;
  logic [CW-1:0]  timer, next_timer;
  logic           ack, next_ack;
  logic [31:0]    rdata, next_rdata;
  logic [20:0]    raddr, next_raddr;
  pfs_erase_t     erase_q, next_erase;
  pfs_pgm_t       pgm_q, next_pgm;
  logic           hold_wr, hold_preset;
  logic [IDX_W-1:0] hold_rd_addr;
  logic [7:0]     hold_rd_data;
  logic           acc, wr_acc, long_busy;
  logic [PTR_W-1:0] eff_ptr;
  pfs_ptr_mode_t  mode;

  // One decode used by both the read and write paths
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction

  assign acc       = wb_cyc_in && wb_stb_in && !ack;
  assign wr_acc    = acc && wb_we_in;
  assign long_busy = (state == ST_ERASE) || (state == ST_PROG_RD) ||
                     (state == ST_PROG_WR) || (state == ST_WAIT) || (state == ST_DONE);
  assign mode      = pfs_ptr_mode_t'(wb_dat_in[TOP_MODE +: 2]);
  // Pre-increment touches the low 21 bits only
  assign eff_ptr   = (mode == PM_PREINC) ?
                     {table_pointer[21], table_pointer[20:0] + 21'h000001} : table_pointer;

  always_comb begin
    next_state     = state;
    next_unlock    = unlock;
    next_pointer   = table_pointer;
    next_latch     = table_latch;
    next_pgm_sel   = pgm_sel;
    next_cfg_sel   = cfg_sel;
    next_erase_sel = erase_sel;
    next_wr_en     = wr_en;
    next_start     = start;
    next_wr_err    = wr_err;
    next_done_flag = done_flag;
    next_rd_hi     = rd_hi;
    next_idx       = idx;
    next_timer     = timer;
    next_ack       = acc;
    next_rdata     = 32'h00000000;
    next_raddr     = raddr;
    next_erase     = '{strobe: 1'b0, row: erase_q.row};
    next_pgm       = '{strobe: 1'b0, addr: pgm_q.addr, data: pgm_q.data};
    hold_wr        = 1'b0;
    hold_preset    = 1'b0;
    hold_rd_addr   = idx;

    // Register reads
    if (acc && !wb_we_in) begin
      if (hit(wb_adr_in, OFS_CTRL)) begin
        next_rdata[7:0] = {pgm_sel, cfg_sel, 1'b0, erase_sel, wr_err, wr_en, start, 1'b0};
      end else if (hit(wb_adr_in, OFS_PTR)) begin
        next_rdata[PTR_W-1:0] = table_pointer;
      end else if (hit(wb_adr_in, OFS_LATCH)) begin
        next_rdata[7:0] = table_latch;
      end else if (hit(wb_adr_in, OFS_STATUS)) begin
        next_rdata[STAT_DONE] = done_flag;
        next_rdata[STAT_BUSY] = state != ST_IDLE;
      end
    end

    // Unlock tracker: any other write breaks the chain
    if (wr_acc) begin
      next_unlock = UL_NONE;
      if (hit(wb_adr_in, OFS_UNLOCK) && wb_sel_in[0]) begin
        if (wb_dat_in[7:0] == KEY_FIRST) begin
          next_unlock = UL_FIRST;
        end else if (wb_dat_in[7:0] == KEY_SECOND && unlock == UL_FIRST) begin
          next_unlock = UL_ARMED;
        end
      end
    end

    // Register writes, ignored while a long cycle holds the core
    if (wr_acc && !long_busy) begin
      if (hit(wb_adr_in, OFS_CTRL) && wb_sel_in[0]) begin
        next_pgm_sel   = wb_dat_in[CTRL_PGM_SEL];
        next_cfg_sel   = wb_dat_in[CTRL_CFG_SEL];
        next_erase_sel = wb_dat_in[CTRL_ERASE_SEL];
        next_wr_en     = wb_dat_in[CTRL_WR_EN];
        next_wr_err    = wb_dat_in[CTRL_WR_ERR];
        if (wb_dat_in[CTRL_START] && !start && state == ST_IDLE) begin
          if (unlock == UL_ARMED && wb_dat_in[CTRL_WR_EN] && wb_dat_in[CTRL_PGM_SEL] &&
              !wb_dat_in[CTRL_CFG_SEL]) begin
            next_start  = 1'b1;
            next_wr_err = 1'b1;
            next_idx    = '0;
            next_timer  = CW'(LONG_CNT);
            next_state  = wb_dat_in[CTRL_ERASE_SEL] ? ST_ERASE : ST_PROG_RD;
          end else begin
            // Refused start: flash untouched, error marked
            next_wr_err = 1'b1;
          end
        end
      end
      if (hit(wb_adr_in, OFS_PTR)) begin
        for (int b = 0; b < 2; b++) begin
          if (wb_sel_in[b]) begin
            next_pointer[b*8 +: 8] = wb_dat_in[b*8 +: 8];
          end
        end
        // Upper lane carries only pointer bits 21:16
        if (wb_sel_in[2]) begin
          next_pointer[21:16] = wb_dat_in[21:16];
        end
      end
      if (hit(wb_adr_in, OFS_LATCH) && wb_sel_in[0]) begin
        next_latch = wb_dat_in[7:0];
      end
      if (hit(wb_adr_in, OFS_STATUS) && wb_sel_in[0] && wb_dat_in[STAT_DONE]) begin
        next_done_flag = 1'b0;
      end
      if (hit(wb_adr_in, OFS_TOP) && wb_sel_in[0] && state == ST_IDLE &&
          (wb_dat_in[TOP_READ] || wb_dat_in[TOP_WRITE])) begin
        unique case (mode)
          PM_POSTINC: next_pointer[20:0] = table_pointer[20:0] + 21'h000001;
          PM_POSTDEC: next_pointer[20:0] = table_pointer[20:0] - 21'h000001;
          PM_PREINC:  next_pointer       = eff_ptr;
          PM_KEEP:    next_pointer       = table_pointer;
        endcase
        if (wb_dat_in[TOP_READ]) begin
          next_raddr = eff_ptr[21:1];
          next_rd_hi = eff_ptr[0];
          next_state = ST_RD;
        end else begin
          hold_wr = 1'b1;
        end
      end
    end

    unique case (state)
      ST_IDLE: begin
      end
      ST_RD: begin
        // Array answers within the cycle its address stands
        next_latch = rd_hi ? flash_rdata_in[15:8] : flash_rdata_in[7:0];
        next_state = ST_IDLE;
      end
      ST_ERASE: begin
        next_erase = '{strobe: 1'b1, row: table_pointer[21:6]};
        next_state = ST_WAIT;
      end
      ST_PROG_RD: begin
        next_state = ST_PROG_WR;
      end
      ST_PROG_WR: begin
        // Array can only clear bits, so an all-ones byte needs no pulse
        if (hold_rd_data != HOLD_INIT) begin
          next_pgm = '{strobe: 1'b1, addr: {table_pointer[21:6], idx}, data: hold_rd_data};
        end
        next_idx   = idx + 6'h01;
        next_state = (idx == IDX_W'(ROW_BYTES - 1)) ? ST_WAIT : ST_PROG_RD;
      end
      ST_WAIT: begin
        next_timer = timer - CW'(1);
        if (timer == CW'(1)) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        hold_preset    = 1'b1;
        next_start     = 1'b0;
        next_erase_sel = 1'b0;
        next_wr_err    = 1'b0;
        next_done_flag = 1'b1;
        next_state     = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase

    if (reset_in) begin
      next_state     = ST_IDLE;
      next_unlock    = UL_NONE;
      next_pointer   = PTR_INIT;
      next_latch     = BYTE_ZERO;
      next_pgm_sel   = 1'b0;
      next_cfg_sel   = 1'b0;
      next_erase_sel = 1'b0;
      next_wr_en     = 1'b0;
      next_start     = 1'b0;
      // Error survives reset so software can see an aborted cycle
      next_wr_err    = wr_err | long_busy;
      next_done_flag = 1'b0;
      next_rd_hi     = 1'b0;
      next_idx       = '0;
      next_timer     = '0;
      next_ack       = 1'b0;
      next_rdata     = 32'h00000000;
      next_raddr     = 21'h000000;
      next_erase     = '{strobe: 1'b0, row: 16'h0000};
      next_pgm       = '{strobe: 1'b0, addr: PTR_INIT, data: BYTE_ZERO};
    end
  end

  always_ff @(posedge clk_in) begin
    state         <= next_state;
    unlock        <= next_unlock;
    table_pointer <= next_pointer;
    table_latch   <= next_latch;
    pgm_sel       <= next_pgm_sel;
    cfg_sel       <= next_cfg_sel;
    erase_sel     <= next_erase_sel;
    wr_en         <= next_wr_en;
    start         <= next_start;
    wr_err        <= next_wr_err;
    done_flag     <= next_done_flag;
    rd_hi         <= next_rd_hi;
    idx           <= next_idx;
    timer         <= next_timer;
    ack           <= next_ack;
    rdata         <= next_rdata;
    raddr         <= next_raddr;
    erase_q       <= next_erase;
    pgm_q         <= next_pgm;
  end

  pfs_hold_mem #(.DEPTH(ROW_BYTES), .AW(IDX_W)) u_hold (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .wr_in       (hold_wr),
    .wr_addr_in  (eff_ptr[IDX_W-1:0]),
    .wr_data_in  (table_latch),
    .preset_in   (hold_preset),
    .rd_addr_in  (hold_rd_addr),
    .rd_data_out (hold_rd_data)
  );

  assign wb_ack_out      = ack;
  assign wb_dat_out      = rdata;
  assign flash_raddr_out = raddr;
  assign flash_erase_out = erase_q;
  assign flash_pgm_out   = pgm_q;
  assign core_stall_out  = long_busy;
endmodule
`default_nettype wire

// ### pfs_pkg.sv
// Package: constants, states and carriers of the program flash sequencer
package pfs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_UNLOCK = 8'h04;
  localparam logic [7:0] OFS_PTR    = 8'h08;
  localparam logic [7:0] OFS_LATCH  = 8'h0C;
  localparam logic [7:0] OFS_TOP    = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // Control register fields
  localparam int CTRL_PGM_SEL   = 7;
  localparam int CTRL_CFG_SEL   = 6;
  localparam int CTRL_ERASE_SEL = 4;
  localparam int CTRL_WR_ERR    = 3;
  localparam int CTRL_WR_EN     = 2;
  localparam int CTRL_START     = 1;
  // Table operation register fields
  localparam int TOP_READ  = 0;
  localparam int TOP_WRITE = 1;
  localparam int TOP_MODE  = 2;
  // Status register fields
  localparam int STAT_DONE = 0;
  localparam int STAT_BUSY = 1;
  // Unlock keys
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // Geometry and reset values
  localparam int          PTR_W     = 22;
  localparam int          ROW_BYTES = 64;
  localparam int          IDX_W     = 6;
  localparam logic [7:0]  HOLD_INIT = 8'hFF;
  localparam logic [21:0] PTR_INIT  = 22'h000000;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  // Long cycle timing
  localparam int CLK_KHZ       = 25000;
  localparam int LONG_TIME_US  = 2000;
  localparam int LONG_CYCLES   = (LONG_TIME_US * CLK_KHZ) / 1000;

  typedef enum logic [1:0] {
    PM_KEEP    = 2'b00,
    PM_POSTINC = 2'b01,
    PM_POSTDEC = 2'b10,
    PM_PREINC  = 2'b11
  } pfs_ptr_mode_t;

  typedef enum logic [1:0] {
    UL_NONE   = 2'b00,
    UL_FIRST  = 2'b01,
    UL_ARMED  = 2'b10
  } pfs_unlock_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_RD      = 3'b001,
    ST_ERASE   = 3'b010,
    ST_PROG_RD = 3'b011,
    ST_PROG_WR = 3'b100,
    ST_WAIT    = 3'b101,
    ST_DONE    = 3'b110
  } pfs_state_t;

  typedef struct packed {
    logic        strobe;
    logic [21:0] addr;
    logic [7:0]  data;
  } pfs_pgm_t;

  typedef struct packed {
    logic        strobe;
    logic [15:0] row;
  } pfs_erase_t;
endpackage

// ### pfs_hold_mem.sv
// Holding registers: byte memory with registered read and bulk preset
`timescale 1ns/100ps
`default_nettype none
module pfs_hold_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          reset_in,
  // Write port
  input  wire logic          wr_in,
  input  wire logic [AW-1:0] wr_addr_in,
  input  wire logic [7:0]    wr_data_in,
  // Bulk preset
  input  wire logic          preset_in,
  // Read port
  input  wire logic [AW-1:0] rd_addr_in,
  output logic      [7:0]    rd_data_out
);
  import pfs_pkg::*;

  logic [7:0] mem      [DEPTH];
  logic [7:0] next_mem [DEPTH];
  logic [7:0] next_rd_data;

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      if (reset_in || preset_in) begin
        next_mem[i] = HOLD_INIT;
      end else if (wr_in && (wr_addr_in == AW'(i))) begin
        next_mem[i] = wr_data_in;
      end else begin
        next_mem[i] = mem[i];
      end
    end
    next_rd_data = reset_in ? HOLD_INIT : mem[rd_addr_in];
  end

  always_ff @(posedge clk_in) begin
    mem         <= next_mem;
    rd_data_out <= next_rd_data;
  end
endmodule
`default_nettype wire

// ### pfs_flash_model.sv
// Flash array model: word store, combinational read, row erase, bit-clear program
`timescale 1ns/100ps
`default_nettype none
module pfs_flash_model
  import pfs_pkg::*;
(
  // Clock
  input  wire logic       clk_in,
  // Array side
  input  wire logic [20:0] raddr_in,
  output logic      [15:0] rdata_out,
  input  wire pfs_erase_t  erase_in,
  input  wire pfs_pgm_t    pgm_in
);
  logic [15:0] mem [128];
  initial begin
    for (int i = 0; i < 128; i++) mem[i] = {8'(i), ~8'(i)};
  end
  // Read is combinational: the word follows the address in the same cycle
  assign rdata_out = mem[raddr_in[6:0]];
  // Only four rows deep; row and word index wrap
  always @(posedge clk_in) begin
    if (erase_in.strobe) begin
      for (int i = 0; i < 32; i++) mem[{erase_in.row[1:0], 5'(i)}] = 16'hFFFF;
    end
    // Programming can only clear bits
    if (pgm_in.strobe && pgm_in.addr[0]) begin
      mem[pgm_in.addr[7:1]][15:8] &= pgm_in.data;
    end
    if (pgm_in.strobe && !pgm_in.addr[0]) begin
      mem[pgm_in.addr[7:1]][7:0] &= pgm_in.data;
    end
  end
endmodule
`default_nettype wire

// ### pfs_sequencer_properties.sv
// Checker: port timing of the flash sequencer
`timescale 1ns/100ps
`default_nettype none
module pfs_seq_props
  import pfs_pkg::*;
#(
  parameter int LONG_CNT = 20
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  // Bus and array side
  input  wire logic       wb_cyc_in,
  input  wire logic       wb_stb_in,
  input  wire logic       wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic       wb_ack_out,
  input  wire pfs_erase_t  flash_erase_out,
  input  wire pfs_pgm_t    flash_pgm_out,
  input  wire logic       core_stall_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic [15:0] len;
  logic [15:0] next_len;
  always_comb begin
    next_len = core_stall_out ? len + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clk_in) begin
    len <= reset_in ? 16'h0000 : next_len;
  end
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held too long");
  a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("request not answered");
  a_erase_stalled: assert property (flash_erase_out.strobe |-> core_stall_out)
    else $error("erase outside long cycle");
  a_erase_single: assert property (flash_erase_out.strobe |=> !flash_erase_out.strobe)
    else $error("erase strobe repeated");
  a_pgm_no_ff: assert property (flash_pgm_out.strobe |-> core_stall_out && flash_pgm_out.data != 8'hFF)
    else $error("blank byte programmed");
  a_pgm_spaced: assert property (flash_pgm_out.strobe |=> !flash_pgm_out.strobe)
    else $error("program strobes adjacent");
  a_start_cause: assert property ($rose(core_stall_out) |-> wb_ack_out && $past(wb_we_in && wb_adr_in == OFS_CTRL && wb_dat_in[CTRL_START] && wb_dat_in[CTRL_WR_EN]))
    else $error("stall without start write");
  a_stall_length: assert property ($fell(core_stall_out) |-> len >= LONG_CNT)
    else $error("long cycle too short");
  a_stall_ends: assert property ($rose(core_stall_out) |-> ##[1:400] !core_stall_out)
    else $error("long cycle never ends");
endmodule
bind pfs_sequencer pfs_seq_props #(.LONG_CNT(LONG_CNT)) i_props (
  .clk_in(clk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out),
  .flash_erase_out(flash_erase_out), .flash_pgm_out(flash_pgm_out),
  .core_stall_out(core_stall_out));
`default_nettype wire

// ### program_flash_self_programming_bench.sv
// Testbench: table reads, erase, program, refusals and reset abort
`timescale 1ns/100ps
`default_nettype none
module program_flash_self_programming_bench;
  import pfs_pkg::*;
  typedef struct packed {
    logic [21:0] ptr;
    logic [1:0]  mode;
    logic [7:0]  byt;
    logic [21:0] nptr;
  } pfs_row_t;
  localparam pfs_row_t ROWS [4] = '{'{22'h10, PM_KEEP, 8'hF7, 22'h10},
    '{22'h11, PM_POSTINC, 8'h08, 22'h12}, '{22'h20, PM_POSTDEC, 8'hEF, 22'h1F},
    '{22'h2F, PM_PREINC, 8'hE7, 22'h30}};
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic wb_cyc_in = 1'b0;
  logic wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [3:0] wb_sel_in = 4'h0;
  logic [31:0] wb_dat_in = 32'h0;
  logic [31:0] wb_dat_out;
  logic wb_ack_out;
  logic [20:0] flash_raddr_out;
  logic [15:0] flash_rdata_in;
  pfs_erase_t flash_erase_out;
  pfs_pgm_t flash_pgm_out;
  logic core_stall_out;
  logic [31:0] rd;
  int n_mismatch = 0;
  int checked = 0;
  int n_pgm = 0;
  int ncyc;
  int p0;
  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) if (flash_pgm_out.strobe === 1'b1) n_pgm <= n_pgm + 1;
  pfs_sequencer #(.LONG_CNT(20)) i_dut (.clk_in(clk_in), .reset_in(reset_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .flash_raddr_out(flash_raddr_out), .flash_rdata_in(flash_rdata_in),
    .flash_erase_out(flash_erase_out), .flash_pgm_out(flash_pgm_out),
    .core_stall_out(core_stall_out));
  pfs_flash_model i_flash (.clk_in(clk_in), .raddr_in(flash_raddr_out),
    .rdata_out(flash_rdata_in), .erase_in(flash_erase_out), .pgm_in(flash_pgm_out));
  task automatic test_done();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // Entered just after a rising edge; ack and data taken at the edge that sees ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ok;
    n = 0;
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= a;
    wb_sel_in <= 4'hF;
    wb_dat_in <= d;
    do begin
      @(posedge clk_in);
      n++;
      ok = wb_ack_out === 1'b1;
    end while (!ok && n < 50);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in <= 1'b0;
    @(posedge clk_in);
    if (!ok) begin
      n_mismatch++;
      $display("wrong value at %0t: bus request not answered", $time);
      test_done();
    end
  endtask
  task automatic go(input logic [7:0] cfg, input logic u, input logic w);
    wb(1'b1, OFS_CTRL, {24'h0, cfg});
    if (u) begin
      wb(1'b1, OFS_UNLOCK, {24'h0, KEY_FIRST});
      wb(1'b1, OFS_UNLOCK, {24'h0, KEY_SECOND});
    end
    wb(1'b1, OFS_CTRL, {24'h0, cfg | 8'h02});
    ncyc = 0;
    while (w && core_stall_out !== 1'b0 && ncyc < 400) begin
      @(negedge clk_in);
      ncyc++;
    end
    if (w) @(posedge clk_in);
    if (ncyc == 400) begin
      n_mismatch++;
      $display("wrong value at %0t: long cycle never ended", $time);
      test_done();
    end
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, OFS_PTR, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    foreach (ROWS[k]) begin
      wb(1'b1, OFS_PTR, {10'h0, ROWS[k].ptr});
      wb(1'b1, OFS_TOP, {28'h0, ROWS[k].mode, 2'b01});
      repeat (2) @(posedge clk_in);
      wb(1'b0, OFS_LATCH, 32'h0);
      chk(rd, {24'h0, ROWS[k].byt});
      wb(1'b0, OFS_PTR, 32'h0);
      chk(rd, {10'h0, ROWS[k].nptr});
    end
    $display("test table reads done");
    wb(1'b1, OFS_PTR, 32'h7F);
    go(8'h94, 1'b1, 1'b1);
    chk(32'(ncyc >= 19), 32'h1);
    chk({16'h0, i_flash.mem[32]}, 32'hFFFF);
    chk({16'h0, i_flash.mem[63]}, 32'hFFFF);
    chk({16'h0, i_flash.mem[31]}, 32'h1FE0);
    chk({16'h0, i_flash.mem[64]}, 32'h40BF);
    wb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h84);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h1);
    wb(1'b1, OFS_STATUS, 32'h1);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    $display("test erase done");
    wb(1'b1, OFS_LATCH, 32'h12);
    wb(1'b1, OFS_PTR, 32'h43);
    wb(1'b1, OFS_TOP, 32'h2);
    wb(1'b1, OFS_LATCH, 32'h34);
    wb(1'b1, OFS_PTR, 32'h44);
    wb(1'b1, OFS_TOP, 32'h2);
    chk({16'h0, i_flash.mem[33]}, 32'hFFFF);
    p0 = n_pgm;
    go(8'h84, 1'b1, 1'b1);
    chk({16'h0, i_flash.mem[33]}, 32'h12FF);
    chk({16'h0, i_flash.mem[34]}, 32'hFF34);
    chk(n_pgm - p0, 32'h2);
    p0 = n_pgm;
    go(8'h84, 1'b1, 1'b1);
    chk(n_pgm - p0, 32'h0);
    $display("test program done");
    go(8'h84, 1'b0, 1'b1);
    chk(ncyc, 32'h0);
    wb(1'b0, OFS_CTRL, 32'h0);
    chk(rd[CTRL_WR_ERR], 32'h1);
    go(8'h80, 1'b1, 1'b1);
    chk(ncyc, 32'h0);
    $display("test refusals done");
    go(8'h94, 1'b1, 1'b0);
    wb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[STAT_BUSY], 32'h1);
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    wb(1'b0, OFS_CTRL, 32'h0);
    chk(rd[CTRL_WR_ERR], 32'h1);
    chk(core_stall_out, 32'h0);
    $display("test reset abort done");
    test_done();
  end
endmodule
`default_nettype wire
